// ===== include/port_adapter_pkg.sv
package port_adapter_pkg;

  localparam int PORT_W = 8;

  // Control byte field positions.
  localparam int BIT_EN1 = 0;
  localparam int BIT_POL1 = 1;
  localparam int BIT_DSEL = 2;
  localparam int BIT_EN2 = 3;
  localparam int BIT_POL2 = 4;
  localparam int BIT_MODE2 = 5;
  localparam int BIT_FLAG2 = 6;
  localparam int BIT_FLAG1 = 7;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] CTL_WMASK = 8'h3F;

  // Register select codes, high select line first.
  localparam logic [1:0] SEL_A_DATA = 2'h0;
  localparam logic [1:0] SEL_A_CTL = 2'h1;
  localparam logic [1:0] SEL_B_DATA = 2'h2;
  localparam logic [1:0] SEL_B_CTL = 2'h3;

  typedef enum {T_OUT, T_DIR, T_CTL} target_e;

  typedef struct packed {
    logic strobe;
    logic rw;
    logic cs_pos_a;
    logic cs_pos_b;
    logic cs_neg;
    logic reg_sel_hi;
    logic reg_sel_lo;
    logic [7:0] data;
  } host_bus_s;

  typedef struct packed {
    logic [7:0] out_data;
    logic [7:0] dir;
    logic [7:0] ctl;
    logic [1:0] armed;
    logic [1:0] last_lvl;
  } port_s;

endpackage

// ===== hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [W-1:0] raw,
  output logic [W-1:0] stable
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } sync_s;

  sync_s st;
  sync_s next_st;

  // A bit only moves once the second and third stages agree, so a
  // level caught mid-flight in the first stage never reaches logic.
  always_comb
  begin
    next_st = st;
    next_st.s1 = raw;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < W; i++)
    begin
      if (st.s2[i] == st.s3[i])
      begin
        next_st.val[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign stable = st.val;

endmodule

// ===== hw/port_adapter.sv
`timescale 1ns/1ps
module port_adapter (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic bus_data_oe,
  input wire logic bus_rw,
  input wire logic bus_strobe,
  input wire logic chip_sel_pos_a,
  input wire logic chip_sel_pos_b,
  input wire logic chip_sel_neg,
  input wire logic reg_sel_lo,
  input wire logic reg_sel_hi,
  input wire logic [7:0] port_a_pins_in,
  output logic [7:0] port_a_pins_out,
  output logic [7:0] port_a_pins_oe,
  input wire logic [7:0] port_b_pins_in,
  output logic [7:0] port_b_pins_out,
  output logic [7:0] port_b_pins_oe,
  input wire logic port_a_edge_in,
  input wire logic port_b_edge_in,
  input wire logic port_a_ctl_line_in,
  output logic port_a_ctl_line_out,
  output logic port_a_ctl_line_oe,
  input wire logic port_b_ctl_line_in,
  output logic port_b_ctl_line_out,
  output logic port_b_ctl_line_oe,
  output logic port_a_irq_n_out,
  output logic port_a_irq_n_oe,
  output logic port_b_irq_n_out,
  output logic port_b_irq_n_oe
);

  localparam int HB_W = $bits(port_adapter_pkg::host_bus_s);
  localparam int SYNC_W = HB_W + 4 + 2 * port_adapter_pkg::PORT_W;

  typedef struct packed {
    port_adapter_pkg::port_s [1:0] port;
    logic strobe_q;
    logic [7:0] rdata;
    logic rd_oe;
  } state_s;

  state_s st;
  state_s next_st;

  port_adapter_pkg::host_bus_s hb;
  logic [1:0] lines_a;
  logic [1:0] lines_b;
  logic [7:0] pins_a;
  logic [7:0] pins_b;
  logic [SYNC_W-1:0] sync_raw;
  logic [SYNC_W-1:0] sync_val;

  logic rise;
  logic fall;
  logic sel;
  logic cur_port;
  port_adapter_pkg::target_e tgt;
  logic [1:0] clr;
  logic [1:0][1:0] set;
  logic [1:0][1:0] lvl;
  logic [1:0][7:0] pins;
  logic [1:0] irq;

  // Every host and peripheral input is asynchronous to mclk.
  assign sync_raw = {bus_strobe, bus_rw, chip_sel_pos_a, chip_sel_pos_b,
                     chip_sel_neg, reg_sel_hi, reg_sel_lo, bus_data_in,
                     port_a_ctl_line_in, port_a_edge_in,
                     port_b_ctl_line_in, port_b_edge_in,
                     port_a_pins_in, port_b_pins_in};

  pin_sync #(
    .W(SYNC_W)
  ) u_sync (
    .mclk(mclk),
    .rstn(rstn),
    .raw(sync_raw),
    .stable(sync_val)
  );

  // Interrupt lines only feed edge logic after synchronising.
  assign {hb, lines_a, lines_b, pins_a, pins_b} = sync_val;

  function automatic port_adapter_pkg::target_e decode(
    input logic lo,
    input logic [7:0] ctl
  );
    if (lo)
    begin
      return port_adapter_pkg::T_CTL;
    end
    else if (ctl[port_adapter_pkg::BIT_DSEL])
    begin
      return port_adapter_pkg::T_OUT;
    end
    return port_adapter_pkg::T_DIR;
  endfunction

  function automatic logic edge_hit(
    input logic cur,
    input logic last,
    input logic pol
  );
    return pol ? (cur & ~last) : (~cur & last);
  endfunction

  function automatic logic [7:0] read_value(
    input port_adapter_pkg::port_s ps,
    input logic [7:0] pv,
    input port_adapter_pkg::target_e t,
    input logic is_b
  );
    logic [7:0] v;
    v = pv;
    if (is_b)
    begin
      v = (ps.dir & ps.out_data) | (~ps.dir & pv);
    end
    unique case (t)
      port_adapter_pkg::T_OUT: return v;
      port_adapter_pkg::T_DIR: return ps.dir;
      port_adapter_pkg::T_CTL: return ps.ctl;
    endcase
  endfunction

  assign pins[0] = pins_a;
  assign pins[1] = pins_b;
  // Index 0 is the edge-only line, index 1 the dual-use line.
  assign lvl[0] = {lines_a[1], lines_a[0]};
  assign lvl[1] = {lines_b[1], lines_b[0]};

  assign rise = ~st.strobe_q & hb.strobe;
  assign fall = st.strobe_q & ~hb.strobe;
  // Selects are only valid while the host holds them steady.
  assign sel = hb.cs_pos_a & hb.cs_pos_b & ~hb.cs_neg;
  assign cur_port = hb.reg_sel_hi;
  assign tgt = decode(hb.reg_sel_lo, st.port[cur_port].ctl);

  always_comb
  begin
    next_st = st;
    next_st.strobe_q = hb.strobe;
    clr = '0;
    set = '0;
    irq = '0;
    if (rise && sel && hb.rw)
    begin
      next_st.rdata = read_value(st.port[cur_port], pins[cur_port], tgt,
                                 cur_port);
      next_st.rd_oe = 1'b1;
    end
    if (fall)
    begin
      next_st.rd_oe = 1'b0;
    end
    for (int p = 0; p < 2; p++)
    begin
      // Flags clear at the end of a data register read strobe.
      clr[p] = fall & sel & hb.rw & (cur_port == p[0])
               & (tgt == port_adapter_pkg::T_OUT);
      set[p][0] = st.port[p].armed[0]
                  & edge_hit(lvl[p][0], st.port[p].last_lvl[0],
                  st.port[p].ctl[port_adapter_pkg::BIT_POL1]);
      set[p][1] = st.port[p].armed[1]
                  & ~st.port[p].ctl[port_adapter_pkg::BIT_MODE2]
                  & edge_hit(lvl[p][1], st.port[p].last_lvl[1],
                  st.port[p].ctl[port_adapter_pkg::BIT_POL2]);
      // A new edge in the clearing cycle survives the clear.
      next_st.port[p].ctl[port_adapter_pkg::BIT_FLAG1] =
        (st.port[p].ctl[port_adapter_pkg::BIT_FLAG1] & ~clr[p])
        | set[p][0];
      next_st.port[p].ctl[port_adapter_pkg::BIT_FLAG2] =
        (st.port[p].ctl[port_adapter_pkg::BIT_FLAG2] & ~clr[p])
        | set[p][1];
      if (clr[p])
      begin
        next_st.port[p].armed = 2'h0;
      end
      if (fall && !sel)
      begin
        next_st.port[p].armed = 2'h3;
      end
      // Line levels are sampled once per strobe, which is why the
      // peripheral must leave a strobe between its two edges.
      if (fall)
      begin
        next_st.port[p].last_lvl = lvl[p];
      end
      // An edge is used up once it sets its flag, so a level left active
      // cannot keep setting a flag that a data read has just cleared.
      next_st.port[p].last_lvl = (next_st.port[p].last_lvl & ~set[p])
                                 | (lvl[p] & set[p]);
      if (fall && sel && !hb.rw && cur_port == p[0])
      begin
        unique case (tgt)
          port_adapter_pkg::T_OUT:
            next_st.port[p].out_data = hb.data;
          port_adapter_pkg::T_DIR:
            next_st.port[p].dir = hb.data;
          port_adapter_pkg::T_CTL:
            next_st.port[p].ctl =
              (next_st.port[p].ctl & ~port_adapter_pkg::CTL_WMASK)
              | (hb.data & port_adapter_pkg::CTL_WMASK);
        endcase
      end
      irq[p] = (st.port[p].ctl[port_adapter_pkg::BIT_FLAG1]
                & st.port[p].ctl[port_adapter_pkg::BIT_EN1])
               | (st.port[p].ctl[port_adapter_pkg::BIT_FLAG2]
                & st.port[p].ctl[port_adapter_pkg::BIT_EN2]);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign bus_data_out = st.rdata;
  assign bus_data_oe = st.rd_oe;

  assign port_a_pins_out = st.port[0].out_data;
  assign port_a_pins_oe = st.port[0].dir;
  assign port_b_pins_out = st.port[1].out_data;
  assign port_b_pins_oe = st.port[1].dir;

  // Output mode of the dual-use line is reduced to a manual level.
  // The handshake and pulse modes are not provided here.
  assign port_a_ctl_line_oe = st.port[0].ctl[port_adapter_pkg::BIT_MODE2];
  assign port_a_ctl_line_out = ~st.port[0].ctl[port_adapter_pkg::BIT_POL2]
                             | st.port[0].ctl[port_adapter_pkg::BIT_EN2];
  assign port_b_ctl_line_oe = st.port[1].ctl[port_adapter_pkg::BIT_MODE2];
  assign port_b_ctl_line_out = ~st.port[1].ctl[port_adapter_pkg::BIT_POL2]
                             | st.port[1].ctl[port_adapter_pkg::BIT_EN2];

  // Only ever pulls low, so several requests can share one wire.
  assign port_a_irq_n_out = 1'b0;
  assign port_a_irq_n_oe = irq[0];
  assign port_b_irq_n_out = 1'b0;
  assign port_b_irq_n_oe = irq[1];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  sequence s_read_a_data_end;
    fall && sel && hb.rw && !cur_port && tgt == port_adapter_pkg::T_OUT;
  endsequence

  sequence s_no_edge_a;
    set[0] == 2'h0;
  endsequence

  sequence s_ctl_write_a;
    fall && sel && !hb.rw && !cur_port && tgt == port_adapter_pkg::T_CTL;
  endsequence

  a_irq_open_drain: assert property (
    port_a_irq_n_out == 1'b0 && port_b_irq_n_out == 1'b0
  ) else $error("irq output drives high");

  a_read_clears_flags: assert property (
    s_read_a_data_end and s_no_edge_a |=>
      st.port[0].ctl[7:6] == 2'h0 ##1 st.port[0].armed == 2'h0
  ) else $error("port A flags survive data read");

  a_disarm_after_clear: assert property (
    s_read_a_data_end |=> st.port[0].armed == 2'h0 && !$rose(
      st.port[0].ctl[port_adapter_pkg::BIT_FLAG1])
  ) else $error("flag set right after clear");

  a_enable_gates_irq: assert property (
    !st.port[0].ctl[port_adapter_pkg::BIT_EN1]
    && !st.port[0].ctl[port_adapter_pkg::BIT_EN2] |-> !port_a_irq_n_oe
  ) else $error("disabled flags reach irq");

  a_flag_drives_irq: assert property (
    $rose(st.port[1].ctl[port_adapter_pkg::BIT_FLAG1])
    && st.port[1].ctl[port_adapter_pkg::BIT_EN1] |-> port_b_irq_n_oe
  ) else $error("enabled flag does not pull irq");

  a_ctl_flags_ro: assert property (
    s_ctl_write_a and s_no_edge_a |=> $stable(st.port[0].ctl[7:6])
  ) else $error("control write changed flags");

  a_dir_write: assert property (
    fall && sel && !hb.rw && !cur_port && tgt == port_adapter_pkg::T_DIR
    |=> port_a_pins_oe == $past(hb.data)
  ) else $error("direction write not applied");

  a_bus_hiz_idle: assert property (
    !hb.strobe |=> !bus_data_oe
  ) else $error("data bus driven outside strobe");

  a_read_b_out: assert property (
    rise && sel && hb.rw && cur_port && tgt == port_adapter_pkg::T_OUT
    && st.port[1].dir == 8'hFF |=> bus_data_out == st.port[1].out_data
  ) else $error("port B output read mismatch");

  a_rise_edge_flag: assert property (
    st.port[0].armed[0] && st.port[0].ctl[port_adapter_pkg::BIT_POL1]
    && !st.port[0].last_lvl[0] && lvl[0][0]
    |=> st.port[0].ctl[port_adapter_pkg::BIT_FLAG1]
  ) else $error("armed rising edge missed");

endmodule

// ===== tb/periph_model.sv
`timescale 1ns/1ps
module periph_model (
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  input wire logic [7:0] a_out,
  input wire logic [7:0] a_oe,
  input wire logic [7:0] b_out,
  input wire logic [7:0] b_oe,
  input wire logic irq_a_o,
  input wire logic irq_a_e,
  input wire logic irq_b_o,
  input wire logic irq_b_e,
  input wire logic [7:0] load,
  output logic [7:0] a_lvl,
  output logic [7:0] b_lvl,
  output logic irq_a,
  output logic irq_b
);
  // The peripheral only drives pins the adapter has released, so a
  // driven pin never fights. A set load bit drags a driven pin low.
  assign a_lvl = (a_oe & a_out & ~load) | (~a_oe & ext_a);
  assign b_lvl = (b_oe & b_out & ~load) | (~b_oe & ext_b);
  // Shared request wires rest high through a pull-up when undriven.
  assign irq_a = irq_a_e ? irq_a_o : 1'b1;
  assign irq_b = irq_b_e ? irq_b_o : 1'b1;
endmodule

// ===== tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("wrong value at %0t got %h exp %h", $time, g, e); \
    end \
  end
module tb_top;
  logic mclk;
  logic rstn;
  port_adapter_pkg::host_bus_s hb;
  logic [7:0] bus_q, rd_data, ext_a, ext_b, cv, dv, ov, load;
  logic [7:0] a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
  logic bus_oe, irq_a_o, irq_a_e, irq_b_o, irq_b_e, irq_a, irq_b;
  logic ca_out, ca_oe, cb_out, cb_oe;
  logic [3:0] lines;
  int error_cnt, n_checks, seed, p, ln, pol, en;
  int ctl_m[2], dir_m[2], out_m[2];

  port_adapter dut_u (.mclk(mclk), .rstn(rstn), .bus_data_in(hb.data),
    .bus_data_out(bus_q), .bus_data_oe(bus_oe), .bus_rw(hb.rw),
    .bus_strobe(hb.strobe), .chip_sel_pos_a(hb.cs_pos_a),
    .chip_sel_pos_b(hb.cs_pos_b), .chip_sel_neg(hb.cs_neg),
    .reg_sel_lo(hb.reg_sel_lo), .reg_sel_hi(hb.reg_sel_hi),
    .port_a_pins_in(a_lvl), .port_a_pins_out(a_out), .port_a_pins_oe(a_oe),
    .port_b_pins_in(b_lvl), .port_b_pins_out(b_out), .port_b_pins_oe(b_oe),
    .port_a_edge_in(lines[0]), .port_b_edge_in(lines[2]),
    .port_a_ctl_line_in(lines[1]), .port_a_ctl_line_out(ca_out),
    .port_a_ctl_line_oe(ca_oe), .port_b_ctl_line_in(lines[3]),
    .port_b_ctl_line_out(cb_out), .port_b_ctl_line_oe(cb_oe),
    .port_a_irq_n_out(irq_a_o), .port_a_irq_n_oe(irq_a_e),
    .port_b_irq_n_out(irq_b_o), .port_b_irq_n_oe(irq_b_e));

  periph_model periph_u (.ext_a(ext_a), .ext_b(ext_b), .a_out(a_out),
    .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe), .irq_a_o(irq_a_o),
    .irq_a_e(irq_a_e), .irq_b_o(irq_b_o), .irq_b_e(irq_b_e),
    .load(load), .a_lvl(a_lvl), .b_lvl(b_lvl), .irq_a(irq_a),
    .irq_b(irq_b));

  initial
  begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Selects, direction and address stay put for the whole strobe and
  // five clocks after it, longer than the synchroniser needs.
  task automatic bus_op(input logic [1:0] sel, input logic r,
                        input logic on, input logic [7:0] wd);
    int k;
    @(posedge mclk);
    hb <= '{strobe: 1'b1, rw: r, cs_pos_a: 1'b1, cs_pos_b: 1'b1,
      cs_neg: ~on, reg_sel_hi: sel[1], reg_sel_lo: sel[0], data: wd};
    for (k = 0; k < 8 && !(bus_oe === 1'b1); k++)
      @(posedge mclk) #1;
    if (r && on && k == 8)
    begin
      error_cnt++;
      stop_test();
    end
    if (!on)
      `CHK(bus_oe, 1'b0)
    rd_data = bus_q;
    @(posedge mclk);
    hb.strobe <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    `CHK(bus_oe, 1'b0)
  endtask

  task automatic wr(input int pt, input logic c, input logic [7:0] d);
    bus_op({pt[0], c}, 1'b0, 1'b1, d);
    if (c)
      ctl_m[pt] = d & 8'h3F;
    else if (ctl_m[pt][2])
      out_m[pt] = d;
    else
      dir_m[pt] = d;
  endtask

  task automatic rd(input int pt, input logic c, input logic [7:0] e);
    bus_op({pt[0], c}, 1'b1, 1'b1, 8'h00);
    `CHK(rd_data, e)
  endtask

  task automatic set_line(input int idx, input logic v);
    @(posedge mclk);
    lines[idx] <= v;
    repeat (8) @(posedge mclk);
    #1;
  endtask

  function automatic logic [7:0] exp_data(input int pt);
    logic [7:0] x;
    logic [7:0] o;
    x = pt ? ext_b : ext_a;
    o = 8'(out_m[pt]);
    // Port A reads the dragged pin, port B its own output register.
    if (pt == 0)
    begin
      o = o & ~load;
    end
    return 8'((dir_m[pt] & o) | (~dir_m[pt] & x));
  endfunction

  initial
  begin
    error_cnt = 0;
    n_checks = 0;
    seed = 32'h3fdd;
    ctl_m = '{0, 0};
    dir_m = '{0, 0};
    out_m = '{0, 0};
    rstn = 1'b0;
    hb = '0;
    hb.cs_neg = 1'b1;
    ext_a = 8'h00;
    ext_b = 8'h00;
    load = 8'h00;
    lines = 4'h0;
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    repeat (4) @(posedge mclk);
    #1;
    `CHK({a_oe, b_oe, bus_oe, irq_a_e, irq_b_e, ca_oe, cb_oe}, 21'h0)
    for (int s = 0; s < 4; s++)
      rd(s / 2, s[0], 8'h00);
    wr(0, 1'b1, 8'hFF);
    rd(0, 1'b1, 8'h3F);
    `CHK({ca_oe, ca_out}, 2'h3)
    wr(0, 1'b1, 8'h00);
    wr(1, 1'b1, 8'h30);
    `CHK({cb_oe, cb_out}, 2'h2)
    for (int i = 0; i < 6; i++)
    begin
      p = i % 2;
      // Port B gets one all-output pass so its register read-back shows.
      dv = (i == 5) ? 8'hFF : 8'($random(seed));
      ov = 8'($random(seed));
      wr(p, 1'b1, 8'h00);
      wr(p, 1'b0, dv);
      wr(p, 1'b1, 8'h04);
      wr(p, 1'b0, ov);
      @(posedge mclk);
      ext_a <= 8'($random(seed));
      ext_b <= 8'($random(seed));
      load <= 8'($random(seed));
      repeat (5) @(posedge mclk);
      #1;
      `CHK(p ? b_oe : a_oe, dv)
      `CHK(p ? b_out : a_out, ov)
      rd(p, 1'b0, exp_data(p));
      wr(p, 1'b1, 8'h00);
      rd(p, 1'b0, dv);
    end
    for (int i = 0; i < 8; i++)
    begin
      p = i % 2;
      ln = (i / 2) % 2;
      pol = i / 4;
      en = (i ^ (i >> 1) ^ (i >> 2)) & 1;
      cv = 8'h04 | 8'(ln ? (en << 3) | (pol << 4) : en | (pol << 1));
      wr(p, 1'b1, cv);
      set_line(p * 2 + ln, !pol);
      bus_op(2'h0, 1'b1, 1'b0, 8'h00);
      set_line(p * 2 + ln, pol);
      `CHK(p ? irq_b_e : irq_a_e, en[0])
      `CHK(p ? irq_b : irq_a, !en[0])
      rd(p, 1'b1, cv | (8'h80 >> ln));
      rd(p, 1'b0, exp_data(p));
      rd(p, 1'b1, cv);
      `CHK(p ? irq_b_e : irq_a_e, 1'b0)
      set_line(p * 2 + ln, !pol);
      rd(p, 1'b1, cv);
      set_line(p * 2 + ln, pol);
      rd(p, 1'b1, cv);
    end
    stop_test();
  end
endmodule
